/* core/rst_clk_regs.vh */
`ifndef RST_CLK_REGS_VH
`define RST_CLK_REGS_VH

// Register byte offsets on the 32-bit Avalon-MM slave.
`define REG_SOURCE_ENABLE 4'h0
`define REG_CONTROL 4'h4
`define REG_CLOCK_SELECT 4'h8
`define REG_STATUS 4'hc

// Source enable register fields.
`define EN_WATCHDOG 0
`define EN_MISSING_CLOCK 1
`define EN_COMPARATOR 2
`define EN_SOFTWARE 3
`define EN_CONVERSION_START 4
`define EN_WIDTH 5
`define EN_RESET_VALUE 5'h1f

// Control register fields.
`define CTL_SOFTWARE_RESET 0
`define CTL_WATCHDOG_LOCK 1

// Clock select register field.
`define CLK_EXTERNAL 0
`define CLK_RESET_VALUE 1'b0

// Status register fields: reset cause flags, then live state.
`define ST_CAUSE_SUPPLY 0
`define ST_CAUSE_WATCHDOG 1
`define ST_CAUSE_MISSING_CLOCK 2
`define ST_CAUSE_COMPARATOR 3
`define ST_CAUSE_SOFTWARE 4
`define ST_CAUSE_CONVERSION_START 5
`define ST_CAUSE_PIN 6
`define ST_CAUSE_POWER_ON 7
`define CAUSE_WIDTH 8
`define ST_CLOCK_EXTERNAL 8
`define ST_WATCHDOG_LOCKED 9
`define ST_MONITOR_ENABLED 10

// Timing counts in clock cycles.
`define SYNC_STAGES 2
`define RELEASE_STAGES 2

`endif

/* core/reset_release_sync.v */
`timescale 1ns/1ps
// Asserts its output at once when the reset input falls and releases it
// only after STAGES clean clock edges.
module reset_release_sync #(
   parameter STAGES = 2
) (
   input wire clk,
   input wire async_rst_n,
   output wire sync_rst_n
);
   reg [STAGES-1:0] chain;

   always @(posedge clk or negedge async_rst_n) begin
      if (!async_rst_n) begin
         chain <= {STAGES{1'b0}};
      end else begin
         chain <= {chain[STAGES-2:0], 1'b1};
      end
   end

   assign sync_rst_n = chain[STAGES-1];
endmodule

/* core/reset_and_clock_select.v */
`timescale 1ns/1ps
// Operation
// - Eight reset sources, power-on included, merge into one system reset output.
// - External low on reset pin resets; device drives pin during power-on reset.
// - Software disables any source except power-on, supply monitor and reset pin.
// - Supply monitor source is enabled only by its dedicated enable pin.
// - Watchdog lock keeps watchdog enabled until the next power-on reset.
// - Any reset selects the internal oscillator as system clock.
// - Software switches system clock source while running, without reset.
`include "rst_clk_regs.vh"

module reset_and_clock_select #(
   parameter SYNC_STAGES = `SYNC_STAGES,
   parameter RELEASE_STAGES = `RELEASE_STAGES
) (
   input wire CLK,
   input wire RST_N,
   input wire [3:0] ADDRESS,
   input wire READ,
   input wire WRITE,
   input wire [3:0] BYTEENABLE,
   input wire [31:0] WRITEDATA,
   output reg [31:0] READDATA,
   output reg WAITREQUEST,
   input wire SUPPLY_MONITOR_ENABLE_PIN,
   input wire SUPPLY_LOW,
   input wire WATCHDOG_EXPIRED,
   input wire MISSING_CLOCK,
   input wire COMPARATOR_LOW,
   input wire CONVERSION_START_PIN,
   input wire RESET_PIN_IN,
   output reg RESET_PIN_OUT,
   output reg RESET_PIN_OE_N,
   output wire SYS_RST_N,
   output reg CLOCK_SELECT_EXTERNAL
);

   // ****************************************************************
   // Pin synchronisers
   // ****************************************************************
   reg [SYNC_STAGES-1:0] monitor_enable_sync;
   reg [SYNC_STAGES-1:0] supply_low_sync;
   reg [SYNC_STAGES-1:0] conversion_start_sync;
   reg [SYNC_STAGES-1:0] reset_pin_sync;
   reg [SYNC_STAGES-1:0] pin_drive_hist;
   wire monitor_enable;
   wire supply_low;
   wire conversion_start;
   wire reset_pin_low;

   always @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         monitor_enable_sync <= {SYNC_STAGES{1'b0}};
         supply_low_sync <= {SYNC_STAGES{1'b0}};
         conversion_start_sync <= {SYNC_STAGES{1'b0}};
         reset_pin_sync <= {SYNC_STAGES{1'b1}};
         pin_drive_hist <= {SYNC_STAGES{1'b1}};
      end else begin
         monitor_enable_sync <= {monitor_enable_sync[SYNC_STAGES-2:0], SUPPLY_MONITOR_ENABLE_PIN};
         supply_low_sync <= {supply_low_sync[SYNC_STAGES-2:0], SUPPLY_LOW};
         conversion_start_sync <= {conversion_start_sync[SYNC_STAGES-2:0], CONVERSION_START_PIN};
         reset_pin_sync <= {reset_pin_sync[SYNC_STAGES-2:0], RESET_PIN_IN};
         pin_drive_hist <= {pin_drive_hist[SYNC_STAGES-2:0], ~RESET_PIN_OE_N};
      end
   end

   assign monitor_enable = monitor_enable_sync[SYNC_STAGES-1];
   assign supply_low = supply_low_sync[SYNC_STAGES-1];
   assign conversion_start = conversion_start_sync[SYNC_STAGES-1];
   // The pin reads back the device's own drive; that echo is masked for as long
   // as it takes to cross the synchroniser, so it never counts as an external reset.
   assign reset_pin_low = ~reset_pin_sync[SYNC_STAGES-1] & ~pin_drive_hist[SYNC_STAGES-1];

   // ****************************************************************
   // Source combining
   // ****************************************************************
   reg [`EN_WIDTH-1:0] source_enable;
   reg software_reset;
   reg watchdog_lock;
   wire watchdog_enabled;
   wire [`CAUSE_WIDTH-1:0] cause_now;
   wire any_source;
   wire combined_rst_n;
   wire sys_rst_n;

   assign watchdog_enabled = source_enable[`EN_WATCHDOG] | watchdog_lock;
   assign cause_now[`ST_CAUSE_SUPPLY] = monitor_enable & supply_low;
   assign cause_now[`ST_CAUSE_WATCHDOG] = watchdog_enabled & WATCHDOG_EXPIRED;
   assign cause_now[`ST_CAUSE_MISSING_CLOCK] = source_enable[`EN_MISSING_CLOCK] & MISSING_CLOCK;
   assign cause_now[`ST_CAUSE_COMPARATOR] = source_enable[`EN_COMPARATOR] & COMPARATOR_LOW;
   assign cause_now[`ST_CAUSE_SOFTWARE] = source_enable[`EN_SOFTWARE] & software_reset;
   assign cause_now[`ST_CAUSE_CONVERSION_START] = source_enable[`EN_CONVERSION_START] & conversion_start;
   assign cause_now[`ST_CAUSE_PIN] = reset_pin_low;
   assign cause_now[`ST_CAUSE_POWER_ON] = 1'b0;
   assign any_source = |cause_now;
   assign combined_rst_n = RST_N & ~any_source;

   // The release is held off for RELEASE_STAGES edges after the last source clears.
   reset_release_sync #(
      .STAGES(RELEASE_STAGES)
   ) u_release (
      .clk(CLK),
      .async_rst_n(combined_rst_n),
      .sync_rst_n(sys_rst_n)
   );

   assign SYS_RST_N = sys_rst_n;

   // ****************************************************************
   // Reset pin driver
   // ****************************************************************
   // The pin is driven low while power is coming up or the supply is low with the supply monitor enabled.
   always @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         RESET_PIN_OUT <= 1'b0;
         RESET_PIN_OE_N <= 1'b0;
      end else begin
         RESET_PIN_OUT <= 1'b0;
         RESET_PIN_OE_N <= ~cause_now[`ST_CAUSE_SUPPLY];
      end
   end

   // ****************************************************************
   // Avalon-MM slave
   // ****************************************************************
   wire request;
   wire accept;
   wire write_byte0;
   reg in_reset;
   reg [`CAUSE_WIDTH-1:0] reset_cause;

   assign request = READ | WRITE;
   assign accept = request & ~WAITREQUEST;
   assign write_byte0 = accept & WRITE & BYTEENABLE[0];

   function [31:0] read_mux;
      input [3:0] addr;
      input [`EN_WIDTH-1:0] enables;
      input lock;
      input clk_ext;
      input mon_en;
      input [`CAUSE_WIDTH-1:0] cause;
      begin
         read_mux = 32'h0000_0000;
         case (addr)
            `REG_SOURCE_ENABLE: begin
               read_mux[`EN_WIDTH-1:0] = enables;
            end
            `REG_CONTROL: begin
               read_mux[`CTL_WATCHDOG_LOCK] = lock;
            end
            `REG_CLOCK_SELECT: begin
               read_mux[`CLK_EXTERNAL] = clk_ext;
            end
            `REG_STATUS: begin
               read_mux[`CAUSE_WIDTH-1:0] = cause;
               read_mux[`ST_CLOCK_EXTERNAL] = clk_ext;
               read_mux[`ST_WATCHDOG_LOCKED] = lock;
               read_mux[`ST_MONITOR_ENABLED] = mon_en;
            end
            default: begin
               read_mux = 32'h0000_0000;
            end
         endcase
      end
   endfunction

   // Every access completes with waitrequest low on the second edge.
   always @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         WAITREQUEST <= 1'b1;
         READDATA <= 32'h0000_0000;
      end else begin
         WAITREQUEST <= ~(request & WAITREQUEST);
         if (READ & WAITREQUEST) begin
            READDATA <= read_mux(ADDRESS, source_enable, watchdog_lock, CLOCK_SELECT_EXTERNAL,
                                 monitor_enable, reset_cause);
         end
      end
   end

   // ****************************************************************
   // Control registers
   // ****************************************************************
   // Registers reset only on power-on and return to defaults synchronously
   // while the system reset is active, so they never feed their own reset.
   always @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         source_enable <= `EN_RESET_VALUE;
         software_reset <= 1'b0;
         CLOCK_SELECT_EXTERNAL <= `CLK_RESET_VALUE;
      end else if (!sys_rst_n) begin
         source_enable <= `EN_RESET_VALUE;
         software_reset <= 1'b0;
         CLOCK_SELECT_EXTERNAL <= `CLK_RESET_VALUE;
      end else if (write_byte0) begin
         case (ADDRESS)
            `REG_SOURCE_ENABLE: begin
               source_enable <= WRITEDATA[`EN_WIDTH-1:0];
            end
            `REG_CONTROL: begin
               // A request made while the source is disabled is dropped, so that
               // enabling the source later does not replay it.
               software_reset <= WRITEDATA[`CTL_SOFTWARE_RESET] & source_enable[`EN_SOFTWARE];
            end
            `REG_CLOCK_SELECT: begin
               CLOCK_SELECT_EXTERNAL <= WRITEDATA[`CLK_EXTERNAL];
            end
            default: begin
               source_enable <= source_enable;
            end
         endcase
      end
   end

   // The lock can only be set by software and only power-on clears it.
   always @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         watchdog_lock <= 1'b0;
      end else if (write_byte0 && ADDRESS == `REG_CONTROL && WRITEDATA[`CTL_WATCHDOG_LOCK]) begin
         watchdog_lock <= 1'b1;
      end
   end

   // ****************************************************************
   // Reset cause capture
   // ****************************************************************
   // Causes are reloaded at the start of each reset and gathered while it lasts.
   // Software clears flags by writing ones to the status register; a cause
   // present in the same cycle wins.
   always @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         in_reset <= 1'b1;
         reset_cause <= 8'h80;
      end else begin
         in_reset <= ~sys_rst_n;
         if (!sys_rst_n && !in_reset) begin
            reset_cause <= cause_now;
         end else if (!sys_rst_n) begin
            reset_cause <= reset_cause | cause_now;
         end else if (write_byte0 && ADDRESS == `REG_STATUS) begin
            reset_cause <= reset_cause & ~WRITEDATA[`CAUSE_WIDTH-1:0];
         end
      end
   end

endmodule

/* bench/rcs_checker_assertions.sv */
`timescale 1ns/1ps
module rcs_checker (
   input wire CLK, input wire RST_N, input wire READ, input wire WRITE, input wire WAITREQUEST,
   input wire SUPPLY_MONITOR_ENABLE_PIN, input wire SUPPLY_LOW, input wire RESET_PIN_IN,
   input wire RESET_PIN_OUT, input wire RESET_PIN_OE_N, input wire SYS_RST_N, input wire CLOCK_SELECT_EXTERNAL
);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_N);
   a_por_hold: assert property (disable iff (1'b0) !RST_N |-> !SYS_RST_N && !RESET_PIN_OE_N)
      else $error("reset output or pin drive missing during power-on reset");
   a_pin_low_only: assert property (!RESET_PIN_OE_N |-> !RESET_PIN_OUT)
      else $error("reset pin driven high");
   a_supply_drives_pin: assert property ((SUPPLY_LOW && SUPPLY_MONITOR_ENABLE_PIN) [*4] |=> !RESET_PIN_OE_N && !SYS_RST_N)
      else $error("supply monitor reset not driven");
   a_monitor_off_quiet: assert property (!SUPPLY_MONITOR_ENABLE_PIN [*4] |=> RESET_PIN_OE_N)
      else $error("pin driven with monitor disabled");
   a_pin_input_resets: assert property (!RESET_PIN_IN [*4] |-> !SYS_RST_N)
      else $error("low reset pin ignored");
   a_release_clean: assert property ($rose(SYS_RST_N) |-> RESET_PIN_IN && !(SUPPLY_LOW && SUPPLY_MONITOR_ENABLE_PIN))
      else $error("reset released while a fixed source is active");
   a_clock_internal: assert property (!SYS_RST_N |=> !CLOCK_SELECT_EXTERNAL)
      else $error("external clock kept through reset");
   a_bus_answer: assert property ($rose(READ || WRITE) |=> !WAITREQUEST)
      else $error("bus answer late");
   a_bus_pulse: assert property (!WAITREQUEST |=> WAITREQUEST)
      else $error("waitrequest low too long");
   c_sys_fall: cover property ($fell(SYS_RST_N));
   c_clk_ext: cover property ($rose(CLOCK_SELECT_EXTERNAL));
   c_pin_drive: cover property ($fell(RESET_PIN_OE_N));
endmodule
bind reset_and_clock_select rcs_checker u_chk (.CLK, .RST_N, .READ, .WRITE, .WAITREQUEST, .SUPPLY_MONITOR_ENABLE_PIN,
   .SUPPLY_LOW, .RESET_PIN_IN, .RESET_PIN_OUT, .RESET_PIN_OE_N, .SYS_RST_N, .CLOCK_SELECT_EXTERNAL);

/* bench/ext_reset_circuit.sv */
`timescale 1ns/1ps
// Open-drain reset line with a pull-up: either party may pull it low.
module ext_reset_circuit (
   input wire oe_n,
   input wire drv,
   input wire pull_low,
   output wire pin
);
   assign pin = ~pull_low & (oe_n | drv);
endmodule

/* bench/reset_and_clock_select_bench.sv */
`timescale 1ns/1ps
`include "rst_clk_regs.vh"
module reset_and_clock_select_bench;
   reg clk = 1'b0;
   reg rst_n = 1'b1;
   reg rd_s = 1'b0, wr_s = 1'b0, mon = 1'b0, slow = 1'b0, ext = 1'b0;
   reg [3:0] adr = 4'h0, src = 4'h0;
   reg [31:0] wd = 32'h0, rd;
   wire [31:0] rdata;
   wire wt, oe_n, pout, sys, cksel, pin;
   integer fail_count = 0, check_count = 0;
   reset_and_clock_select dut (.CLK(clk), .RST_N(rst_n), .ADDRESS(adr), .READ(rd_s), .WRITE(wr_s),
      .BYTEENABLE(4'hf), .WRITEDATA(wd), .READDATA(rdata), .WAITREQUEST(wt),
      .SUPPLY_MONITOR_ENABLE_PIN(mon), .SUPPLY_LOW(slow), .WATCHDOG_EXPIRED(src[0]), .MISSING_CLOCK(src[1]),
      .COMPARATOR_LOW(src[2]), .CONVERSION_START_PIN(src[3]), .RESET_PIN_IN(pin), .RESET_PIN_OUT(pout),
      .RESET_PIN_OE_N(oe_n), .SYS_RST_N(sys), .CLOCK_SELECT_EXTERNAL(cksel));
   ext_reset_circuit far (.oe_n(oe_n), .drv(pout), .pull_low(ext), .pin(pin));
   initial begin
      forever #12.5 clk = ~clk;
   end
   task test_done;
      begin
         $display("checks %0d mismatches %0d", check_count, fail_count);
         if (fail_count == 0 && check_count > 0) $display("== PASSED ==");
         else $display("== FAILED ==");
         $finish;
      end
   endtask
   task chk(input [31:0] g, input [31:0] e);
      begin
         check_count = check_count + 1;
         if (g !== e) begin
            $display("[ERR] %0t got %h expected %h", $time, g, e);
            fail_count = fail_count + 1;
         end
      end
   endtask
   task bus(input w, input [3:0] a, input [31:0] d);
      begin
         @(posedge clk);
         adr <= a; wd <= d; wr_s <= w; rd_s <= ~w;
         do @(posedge clk); while (wt !== 1'b0);
         rd = rdata;
         wr_s <= 1'b0; rd_s <= 1'b0;
      end
   endtask
   task wsys(input v);
      integer i;
      begin
         i = 0;
         while (sys !== v && i < 40) begin
            @(posedge clk); #1; i = i + 1;
         end
         chk(sys, v);
      end
   endtask
   task t_power_on;
      begin
         wsys(1'b1);
         bus(0, `REG_SOURCE_ENABLE, 0); chk(rd, `EN_RESET_VALUE);
         chk(cksel, 1'b0);
         bus(0, `REG_STATUS, 0);
         chk(rd, 32'h80);
         bus(0, 4'h2, 0); chk(rd, 32'h0);
      end
   endtask
   task t_clock_switch;
      begin
         bus(1, `REG_CLOCK_SELECT, 32'h1); #1;
         chk(cksel, 1'b1);
         chk(sys, 1'b1);
         bus(1, `REG_SOURCE_ENABLE, 32'h17);
         bus(1, `REG_CONTROL, 32'h1);
         bus(1, `REG_SOURCE_ENABLE, 32'h1f); #1;
         chk(sys, 1'b1);
         bus(1, `REG_CONTROL, 32'h1); wsys(1'b0); wsys(1'b1);
         chk(cksel, 1'b0);
         bus(0, `REG_STATUS, 0); chk(rd[7:0], 8'h10);
      end
   endtask
   task t_source(input integer k, input [4:0] en, input [7:0] cause);
      begin
         @(posedge clk) src[k] <= 1'b1;
         wsys(1'b0);
         @(posedge clk) src <= 4'h0;
         wsys(1'b1);
         bus(0, `REG_STATUS, 0); chk(rd[7:0], cause);
         bus(1, `REG_SOURCE_ENABLE, {27'h0, ~en});
         @(posedge clk) src[k] <= 1'b1;
         repeat (8) @(posedge clk);
         #1 chk(sys, 1'b1);
         @(posedge clk) src <= 4'h0;
         bus(1, `REG_SOURCE_ENABLE, 32'h1f);
      end
   endtask
   task t_supply;
      begin
         @(posedge clk) slow <= 1'b1;
         repeat (8) @(posedge clk);
         #1 chk(sys, 1'b1);
         bus(1, `REG_SOURCE_ENABLE, 32'h0);
         @(posedge clk) mon <= 1'b1;
         wsys(1'b0);
         repeat (2) @(posedge clk);
         #1 chk(pin, 1'b0);
         @(posedge clk) slow <= 1'b0;
         wsys(1'b1);
         bus(0, `REG_STATUS, 0);
         chk(rd[10:0], 11'h401);
         @(posedge clk) mon <= 1'b0;
      end
   endtask
   task t_ext_pin;
      begin
         @(posedge clk) ext <= 1'b1;
         wsys(1'b0);
         @(posedge clk) ext <= 1'b0;
         wsys(1'b1);
         bus(0, `REG_STATUS, 0);
         chk(rd[7:0], 8'h40);
      end
   endtask
   task t_lock;
      begin
         bus(1, `REG_CONTROL, 32'h2);
         bus(0, `REG_CONTROL, 0);
         chk(rd, 32'h2);
         repeat (2) begin
            bus(1, `REG_SOURCE_ENABLE, 32'h0);
            @(posedge clk) src[0] <= 1'b1;
            wsys(1'b0);
            @(posedge clk) src <= 4'h0;
            wsys(1'b1);
         end
         @(posedge clk) rst_n <= 1'b0;
         repeat (4) @(posedge clk);
         rst_n <= 1'b1;
         wsys(1'b1);
         bus(0, `REG_STATUS, 0); chk(rd[9], 1'b0);
      end
   endtask
   initial begin
      rst_n <= 1'b0;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      t_power_on;
      t_clock_switch;
      t_source(0, 5'h01, 8'h02);
      t_source(1, 5'h02, 8'h04);
      t_source(2, 5'h04, 8'h08);
      t_source(3, 5'h10, 8'h20);
      t_supply;
      t_ext_pin;
      t_lock;
      test_done;
   end
   initial begin
      #200000;
      fail_count = fail_count + 1;
      test_done;
   end
endmodule
